// ==== core/pll_status_and_fine_delay_regs.sv ====
// module: pll readback status, reference monitor config, fine delay regs
//
// Contract
// - oscillator-above status bit is one exactly while oscillator exceeds threshold; here it follows the pin through the synchroniser, four edges late.
// - oscillator-above indication sits at status bit 3, with bits 6:4 above it and bits 2:0 below it.
// - status bit 2 shows secondary reference above threshold chosen by bit 6.
// - status bit 1 shows primary reference above threshold chosen by bit 6.
// - status bit 0 shows digital lock, zero unlocked, one locked.
// - bit 0 at 0x0A0 bypasses or inserts the fine delay.
// - bits 5:3 at 0x0A1 set ramp capacitor count for the delay.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module pll_status_and_fine_delay_regs (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  input wire logic i_tuned_oscillator_above,
  input wire logic i_primary_reference_input_above,
  input wire logic i_secondary_reference_input_above,
  input wire logic i_pll_locked,
  input wire logic i_cal_done,
  input wire logic i_holdover_active,
  input wire logic i_secondary_reference_selected,
  output logic o_ref_threshold_sel,
  output logic o_delay_bypass,
  output logic [2:0] o_ramp_caps,
  output logic [2:0] o_ramp_current,
  output logic o_irq
);

  // request carrier
  pll_status_pkg::reg_req_t req;

  assign req.addr = i_addr;
  assign req.wdata = i_wdata;
  assign req.wr = i_wr;
  assign req.rd = i_rd;

  // raw analog-side indications gathered into one word
  pll_status_pkg::pll_status_t raw_status;
  pll_status_pkg::pll_status_t live_status;
  logic [6:0] raw_bits;
  logic [6:0] live_bits;

  assign raw_status.cal_done = i_cal_done;
  assign raw_status.holdover_active = i_holdover_active;
  assign raw_status.secondary_reference_selected =
    i_secondary_reference_selected;
  assign raw_status.tuned_oscillator_above =
    i_tuned_oscillator_above;
  assign raw_status.secondary_reference_input_above =
    i_secondary_reference_input_above;
  assign raw_status.primary_reference_input_above =
    i_primary_reference_input_above;
  assign raw_status.pll_locked = i_pll_locked;
  assign raw_bits = raw_status;

  // pins are asynchronous to the register clock
  status_pin_sync #(
    .WIDTH(pll_status_pkg::STATUS_W)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_async(raw_bits),
    .o_sync(live_bits)
  );

  assign live_status = live_bits;

  // address decode
  wire hit_ref_cfg;
  wire hit_status;
  wire hit_bypass;
  wire hit_ramp;
  wire hit_irq_status;
  wire hit_irq_mask;

  assign hit_ref_cfg = (req.addr == pll_status_pkg::REF_MON_CFG_OFS);
  assign hit_status = (req.addr == pll_status_pkg::PLL_READBACK_STATUS_OFS);
  assign hit_bypass =
    (req.addr == pll_status_pkg::OUTPUT_DELAY_BYPASS_CTRL_OFS);
  assign hit_ramp = (req.addr == pll_status_pkg::OUTPUT_DELAY_RAMP_CONFIG_OFS);
  assign hit_irq_status = (req.addr == pll_status_pkg::IRQ_STATUS_OFS);
  assign hit_irq_mask = (req.addr == pll_status_pkg::IRQ_MASK_OFS);

  // write strobes and the irq status read strobe; the status word has no write strobe at all
  wire wr_ref_cfg;
  wire wr_bypass;
  wire wr_ramp;
  wire wr_irq_mask;
  wire rd_irq_status;

  assign wr_ref_cfg = req.wr & hit_ref_cfg;
  assign wr_bypass = req.wr & hit_bypass;
  assign wr_ramp = req.wr & hit_ramp;
  assign wr_irq_mask = req.wr & hit_irq_mask;
  assign rd_irq_status = req.rd & hit_irq_status;

  // storage
  logic [7:0] ref_mon_cfg;
  logic [7:0] output_delay_bypass_ctrl;
  logic [7:0] output_delay_ramp_config;
  logic [6:0] irq_status;
  logic [6:0] irq_mask;
  logic [6:0] prev_live;

  // reference monitor config; bit 6 picks the reference threshold
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ref_mon_cfg <= pll_status_pkg::REF_MON_CFG_RST;
    end else if (wr_ref_cfg) begin
      ref_mon_cfg <= req.wdata;
    end
  end

  // fine delay bypass control
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      output_delay_bypass_ctrl <= pll_status_pkg::DELAY_BYPASS_RST;
    end else if (wr_bypass) begin
      output_delay_bypass_ctrl <= req.wdata;
    end
  end

  // ramp capacitors and ramp current
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      output_delay_ramp_config <= pll_status_pkg::DELAY_RAMP_RST;
    end else if (wr_ramp) begin
      output_delay_ramp_config <= req.wdata;
    end
  end

  // interrupt mask, same layout as the status word
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_mask <= pll_status_pkg::IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask <= req.wdata[6:0];
    end
  end

  // events: any change of a synchronised indication
  wire [6:0] status_event;
  wire [6:0] next_irq_status;

  assign status_event = live_bits ^ prev_live;
  // set wins over the read clear so no edge is lost
  assign next_irq_status =
    (rd_irq_status ? 7'h00 : irq_status) | status_event;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      prev_live <= 7'h00;
    end else begin
      prev_live <= live_bits;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      irq_status <= pll_status_pkg::IRQ_STATUS_RST;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // readback word; status is live and never latched or cleared
  wire [7:0] status_word;
  wire [7:0] irq_status_word;
  wire [7:0] irq_mask_word;
  wire [7:0] next_rd_data;

  assign status_word = {1'b0, live_status};
  assign irq_status_word = {1'b0, irq_status};
  assign irq_mask_word = {1'b0, irq_mask};

  // data only in the cycle after the read strobe, zero otherwise
  assign next_rd_data =
    !req.rd ? 8'h00 :
    hit_ref_cfg ? ref_mon_cfg :
    hit_status ? status_word :
    hit_bypass ? output_delay_bypass_ctrl :
    hit_ramp ? output_delay_ramp_config :
    hit_irq_status ? irq_status_word :
    hit_irq_mask ? irq_mask_word :
    pll_status_pkg::UNMAPPED_READ;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  // outputs from flops; o_irq loads on the same edge as irq_status
  wire next_irq;

  assign next_irq = |(next_irq_status & irq_mask);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end

  // control fields drive the analog side from flops that mirror their register
  wire next_thresh_sel;
  wire next_bypass;
  wire [2:0] next_caps;
  wire [2:0] next_current;

  assign next_thresh_sel = wr_ref_cfg ?
    req.wdata[pll_status_pkg::REF_THRESH_SEL_BIT] :
    ref_mon_cfg[pll_status_pkg::REF_THRESH_SEL_BIT];
  assign next_bypass = wr_bypass ?
    req.wdata[pll_status_pkg::DELAY_BYPASS_BIT] :
    output_delay_bypass_ctrl[pll_status_pkg::DELAY_BYPASS_BIT];
  assign next_caps = wr_ramp ?
    req.wdata[pll_status_pkg::RAMP_CAPS_LSB +: pll_status_pkg::RAMP_CAPS_W] :
    output_delay_ramp_config[pll_status_pkg::RAMP_CAPS_LSB +:
      pll_status_pkg::RAMP_CAPS_W];
  assign next_current = wr_ramp ?
    req.wdata[pll_status_pkg::RAMP_CURRENT_LSB +:
      pll_status_pkg::RAMP_CURRENT_W] :
    output_delay_ramp_config[pll_status_pkg::RAMP_CURRENT_LSB +:
      pll_status_pkg::RAMP_CURRENT_W];

  // the outputs follow a write on the very next edge
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_ref_threshold_sel <=
        pll_status_pkg::REF_MON_CFG_RST[pll_status_pkg::REF_THRESH_SEL_BIT];
      o_delay_bypass <=
        pll_status_pkg::DELAY_BYPASS_RST[pll_status_pkg::DELAY_BYPASS_BIT];
      o_ramp_caps <= pll_status_pkg::DELAY_RAMP_RST[
        pll_status_pkg::RAMP_CAPS_LSB +: pll_status_pkg::RAMP_CAPS_W];
      o_ramp_current <= pll_status_pkg::DELAY_RAMP_RST[
        pll_status_pkg::RAMP_CURRENT_LSB +: pll_status_pkg::RAMP_CURRENT_W];
    end else begin
      o_ref_threshold_sel <= next_thresh_sel;
      o_delay_bypass <= next_bypass;
      o_ramp_caps <= next_caps;
      o_ramp_current <= next_current;
    end
  end

endmodule

`default_nettype wire

// ==== core/pll_status_pkg.sv ====
// package: register map, field layout and carriers for pll status block
package pll_status_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // register indices, one byte each on the plain port
  localparam logic [9:0] REF_MON_CFG_OFS = 10'h01A;
  localparam logic [9:0] PLL_READBACK_STATUS_OFS = 10'h01F;
  localparam logic [9:0] OUTPUT_DELAY_BYPASS_CTRL_OFS = 10'h0A0;
  localparam logic [9:0] OUTPUT_DELAY_RAMP_CONFIG_OFS = 10'h0A1;
  localparam logic [9:0] IRQ_STATUS_OFS = 10'h230;
  localparam logic [9:0] IRQ_MASK_OFS = 10'h231;

  // field positions
  localparam int REF_THRESH_SEL_BIT = 6;
  localparam int LOCK_BIT = 0;
  localparam int PRI_REF_ABOVE_BIT = 1;
  localparam int SEC_REF_ABOVE_BIT = 2;
  localparam int OSC_ABOVE_BIT = 3;
  localparam int SEC_REF_SELECTED_BIT = 4;
  localparam int HOLDOVER_ACTIVE_BIT = 5;
  localparam int CAL_DONE_BIT = 6;
  localparam int DELAY_BYPASS_BIT = 0;
  localparam int RAMP_CURRENT_LSB = 0;
  localparam int RAMP_CURRENT_W = 3;
  localparam int RAMP_CAPS_LSB = 3;
  localparam int RAMP_CAPS_W = 3;
  localparam int STATUS_W = 7;

  // reset values
  localparam logic [7:0] REF_MON_CFG_RST = 8'h00;
  localparam logic [7:0] DELAY_BYPASS_RST = 8'h01;
  localparam logic [7:0] DELAY_RAMP_RST = 8'h00;
  localparam logic [6:0] IRQ_STATUS_RST = 7'h00;
  localparam logic [6:0] IRQ_MASK_RST = 7'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // live readback word, bit 6 down to bit 0
  typedef struct packed {
    logic cal_done;
    logic holdover_active;
    logic secondary_reference_selected;
    logic tuned_oscillator_above;
    logic secondary_reference_input_above;
    logic primary_reference_input_above;
    logic pll_locked;
  } pll_status_t;

  // one register access from the plain port
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ==== core/status_pin_sync.sv ====
// module: three-stage pin synchroniser with agreement filter per bit
`timescale 1ns/10ps
`default_nettype none

module status_pin_sync #(
  parameter int WIDTH = 7
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta;
      logic stage2;
      logic stage3;
      logic held;
      // first flop feeds only the second; filter looks at 2 and 3
      always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
          meta <= 1'b0;
          stage2 <= 1'b0;
          stage3 <= 1'b0;
          held <= 1'b0;
        end else begin
          meta <= i_async[g];
          stage2 <= meta;
          stage3 <= stage2;
          if (stage2 == stage3) begin
            held <= stage3;
          end
        end
      end
      assign o_sync[g] = held;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== dv/pll_status_regs_properties.sv ====
// checker: port-level properties of the pll status register block
`timescale 1ns/10ps
`default_nettype none
module pll_status_regs_properties (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rd_data,
  input wire logic i_tuned_oscillator_above,
  input wire logic i_primary_reference_input_above,
  input wire logic i_secondary_reference_input_above,
  input wire logic i_pll_locked,
  input wire logic i_cal_done,
  input wire logic o_ref_threshold_sel,
  input wire logic o_delay_bypass,
  input wire logic [2:0] o_ramp_caps,
  input wire logic [2:0] o_ramp_current
);
  localparam logic [9:0] ST = pll_status_pkg::PLL_READBACK_STATUS_OFS;
  // status is only meaningful once the sync chain has refilled
  logic [3:0] up;
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) up <= 4'h0;
    else if (up != 4'hF) up <= up + 4'h1;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_quiet_rd(pin);
    $stable(pin) [*6] ##0 (up == 4'hF && i_rd && i_addr == ST);
  endsequence
  property p_osc;
    s_quiet_rd(i_tuned_oscillator_above) |=>
      o_rd_data[3] == $past(i_tuned_oscillator_above);
  endproperty
  a_osc: assert property (p_osc) else $error("osc bit wrong");
  property p_sec;
    s_quiet_rd(i_secondary_reference_input_above) |=>
      o_rd_data[2] == $past(i_secondary_reference_input_above);
  endproperty
  a_sec: assert property (p_sec) else $error("sec ref bit wrong");
  property p_pri;
    s_quiet_rd(i_primary_reference_input_above) |=>
      o_rd_data[1] == $past(i_primary_reference_input_above);
  endproperty
  a_pri: assert property (p_pri) else $error("pri ref bit wrong");
  property p_lock;
    s_quiet_rd(i_pll_locked) |=> o_rd_data[0] == $past(i_pll_locked);
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_cal;
    s_quiet_rd(i_cal_done) |=> o_rd_data[7:6] == {1'b0, $past(i_cal_done)};
  endproperty
  a_cal: assert property (p_cal) else $error("upper bits wrong");
  property p_bypass;
    logic [7:0] d;
    (i_wr && i_addr == 10'h0A0, d = i_wdata) |=> o_delay_bypass == d[0];
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");
  property p_caps;
    logic [7:0] d;
    (i_wr && i_addr == 10'h0A1, d = i_wdata) |=>
      o_ramp_caps == d[5:3] && o_ramp_current == d[2:0];
  endproperty
  a_caps: assert property (p_caps) else $error("ramp field wrong");
  property p_thr;
    logic [7:0] d;
    (i_wr && i_addr == 10'h01A, d = i_wdata) |=> o_ref_threshold_sel == d[6];
  endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");
  property p_ro;
    i_wr && i_addr == ST |=> $stable({o_delay_bypass, o_ramp_caps,
      o_ramp_current, o_ref_threshold_sel});
  endproperty
  a_ro: assert property (p_ro) else $error("status write took effect");
endmodule
bind pll_status_and_fine_delay_regs pll_status_regs_properties u_props (
  .i_ref_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rd_data,
  .i_tuned_oscillator_above, .i_primary_reference_input_above,
  .i_secondary_reference_input_above, .i_pll_locked, .i_cal_done,
  .o_ref_threshold_sel, .o_delay_bypass, .o_ramp_caps, .o_ramp_current);
`default_nettype wire

// ==== dv/pll_status_and_fine_delay_regs_tb.sv ====
// testbench: register-port tests of the pll status block
`timescale 1ns/10ps
`default_nettype none
module pll_status_and_fine_delay_regs_tb;
  localparam logic [9:0] ST = pll_status_pkg::PLL_READBACK_STATUS_OFS;
  localparam logic [9:0] IS = pll_status_pkg::IRQ_STATUS_OFS;
  localparam logic [9:0] IM = pll_status_pkg::IRQ_MASK_OFS;
  logic clk = 1'b0;
  logic rst, wr, rd, thr, byp, irq;
  logic [9:0] addr;
  logic [7:0] wdata, rd_data;
  logic [2:0] caps, cur;
  pll_status_pkg::pll_status_t st;
  int num_errors = 0;
  int n_compared = 0;
  int i;
  initial forever #10 clk = ~clk;
  pll_status_and_fine_delay_regs DUT (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rd_data), .i_tuned_oscillator_above(st[3]),
    .i_primary_reference_input_above(st[1]),
    .i_secondary_reference_input_above(st[2]), .i_pll_locked(st[0]),
    .i_cal_done(st[6]), .i_holdover_active(st[5]),
    .i_secondary_reference_selected(st[4]), .o_ref_threshold_sel(thr),
    .o_delay_bypass(byp), .o_ramp_caps(caps), .o_ramp_current(cur),
    .o_irq(irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rd_data, exp);
  endtask
  task automatic pins(input logic [6:0] v, input int n);
    @(posedge clk);
    st <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run;
    $display("compared=%0d mismatches=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 10'h000; wdata = 8'h00;
    st = 7'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1 chk({7'h00, byp}, 8'h01);
    chk({2'h0, caps, cur}, 8'h00);
    rd_chk(10'h0A0, 8'h01);
    rd_chk(10'h0A1, 8'h00);
    rd_chk(10'h3FF, 8'h00);
    $display("test reset values done");
    wr_reg(10'h0A0, 8'h00);
    chk({7'h00, byp}, 8'h00);
    rd_chk(10'h0A0, 8'h00);
    wr_reg(10'h0A0, 8'hFF);
    chk({7'h00, byp}, 8'h01);
    for (i = 0; i < 8; i++) begin
      wr_reg(10'h0A1, {2'h0, i[2:0], ~i[2:0]});
      chk({2'h0, caps, cur}, {2'h0, i[2:0], ~i[2:0]});
    end
    wr_reg(10'h01A, 8'h40);
    chk({7'h00, thr}, 8'h01);
    wr_reg(10'h01A, 8'hBF);
    chk({7'h00, thr}, 8'h00);
    $display("test control registers done");
    // walking one, then a write to status must change nothing
    for (i = 0; i < 7; i++) begin
      pins(7'h01 << i, 6);
      rd_chk(ST, 8'h01 << i);
      wr_reg(ST, 8'hFF);
      rd_chk(ST, 8'h01 << i);
    end
    $display("test status bits done");
    pins(7'h00, 6);
    wr_reg(IM, 8'h08);
    rd_chk(IM, 8'h08);
    // every bit rose and fell during the walk, nothing cleared it yet
    chk({7'h00, irq}, 8'h01);
    rd_chk(IS, 8'h7F);
    chk({7'h00, irq}, 8'h00);
    pins(7'h08, 7);
    chk({7'h00, irq}, 8'h01);
    rd_chk(ST, 8'h08);
    rd_chk(IS, 8'h08);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h00);
    pins(7'h09, 7);
    chk({7'h00, irq}, 8'h00);
    rd_chk(IS, 8'h01);
    $display("test interrupts done");
    complete_run();
  end
endmodule
`default_nettype wire
